// ---- hdl/loop_panel.sv ----
// front panel, switch, alignment and error supervisor of the four-channel loop detector
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`include "loop_params.svh"
module loop_panel #(
  parameter int MS_TICK_CYCLES = `CLK_MHZ * `TICK_US,
  parameter logic SUPPORTED_TYPE = `LOOP_TYPE_OK
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite register slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // front panel pins, asynchronous
  input wire logic button_n,
  input wire logic [7:0] dip_switches,
  input wire logic [1:0] freq_jumpers,
  input wire logic ext_reset_n,
  // same-clock status from the rest of the detector
  input wire logic int_reset,
  input wire logic rx_busy,
  input wire logic tx_busy,
  input wire logic [3:0] chan_detect,
  input wire logic [3:0] meas_done,
  input wire logic [3:0] meas_short,
  input wire logic [3:0] meas_open,
  input wire logic [3:0] meas_freq_bad,
  // indicators and terminal output
  output logic [3:0] channel_indicators,
  output logic heartbeat_indicator,
  output logic rx_indicator,
  output logic tx_indicator,
  output logic fault_indicator,
  output logic fault_output,
  // to the measurement side
  output logic [3:0] chan_aligning,
  output logic [3:0] detect_out,
  output logic [3:0] freq_range,
  output logic [1:0] serial_freq_block,
  output logic [1:0] class_degraded,
  output logic detector_reset
);
  localparam int TW = $clog2(MS_TICK_CYCLES + 1);

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    merge = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
  endfunction

  logic [11:0] pin_meta_r;
  logic [11:0] pin_sync_r;
  logic [7:0] sw_s;
  logic [1:0] jmp_s;
  logic ext_n_s;
  logic [TW-1:0] tick_cnt_r;
  logic ms_tick;
  logic btn_short;
  logic btn_align;
  logic btn_reset;
  logic dev_rst;
  logic aw_full_r;
  logic w_full_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;
  logic sync_en_r;
  logic [7:0] blank_to_r;
  logic [`MS_W-1:0] align_max_r;
  logic [3:0] sys_r [2];
  logic [1:0] sys_realign;
  logic [1:0] type_fault;
  logic jumper_fault;
  logic blank_r;
  logic [`MS_W-1:0] hb_cnt_r;
  logic hb_r;
  logic [3:0] blink;
  loop_pkg::err_code_t disp_code [4];
  loop_pkg::err_code_t err_r [4];
  logic [3:0] faulty;
  logic [31:0] ctrl_new;
  logic [31:0] amax_new;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic wr_ok;

  // two flops on every asynchronous pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_r <= `PIN_SYNC_RST;
      pin_sync_r <= `PIN_SYNC_RST;
    end else begin
      pin_meta_r <= {ext_reset_n, freq_jumpers, dip_switches, button_n};
      pin_sync_r <= pin_meta_r;
    end
  end
  assign sw_s = pin_sync_r[8:1];
  assign jmp_s = pin_sync_r[10:9];
  assign ext_n_s = pin_sync_r[11];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= ms_tick ? '0 : tick_cnt_r + 1'b1;
    end
  end
  assign ms_tick = (tick_cnt_r == TW'(MS_TICK_CYCLES - 1));

  button_classifier u_button (
    .aclk(aclk),
    .aresetn(aresetn),
    .ms_tick(ms_tick),
    .pressed(~pin_sync_r[0]),
    .short_press(btn_short),
    .align_press(btn_align),
    .reset_press(btn_reset)
  );

  // the configuration survives these resets, like settings kept in non-volatile storage
  assign dev_rst = btn_reset | ~ext_n_s | int_reset;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detector_reset <= 1'b0;
    end else begin
      detector_reset <= dev_rst;
    end
  end

  // axi4-lite write channel: address and data accepted in either order
  assign wr_fire = aw_full_r & w_full_r & ~bvalid;
  assign wr_ok = (awaddr_r == `REG_CTRL) | (awaddr_r == `REG_ALIGN_MAX) | (awaddr_r == `REG_SYS0) |
                 (awaddr_r == `REG_SYS1) | (awaddr_r == `REG_STATUS) | (awaddr_r == `REG_ERRORS) |
                 (awaddr_r == `REG_SWITCHES);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_full_r <= 1'b1;
        awaddr_r <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_full_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
        wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  assign ctrl_new = merge({16'h0000, blank_to_r, 7'h00, sync_en_r}, wdata_r, wstrb_r);
  assign amax_new = merge({16'h0000, align_max_r}, wdata_r, wstrb_r);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_en_r <= 1'b0;
      blank_to_r <= `BLANK_RST;
      align_max_r <= `ALIGN_LIMIT_RST;
    end else if (wr_fire && awaddr_r == `REG_CTRL) begin
      sync_en_r <= ctrl_new[`CTRL_SYNC_BIT];
      blank_to_r <= ctrl_new[`CTRL_BLANK_MSB:`CTRL_BLANK_LSB];
    end else if (wr_fire && awaddr_r == `REG_ALIGN_MAX) begin
      align_max_r <= amax_new[`MS_W-1:0];
    end
  end

  // axi4-lite read channel, data one cycle after the address is taken
  always_comb begin
    rd_ok = 1'b1;
    case (araddr)
      `REG_CTRL: rd_mux = {16'h0000, blank_to_r, 7'h00, sync_en_r};
      `REG_ALIGN_MAX: rd_mux = {16'h0000, align_max_r};
      `REG_SYS0: rd_mux = {28'h000_0000, sys_r[0]};
      `REG_SYS1: rd_mux = {28'h000_0000, sys_r[1]};
      `REG_STATUS: rd_mux = {20'h0_0000, class_degraded, blank_r, fault_output, detect_out, chan_aligning};
      `REG_ERRORS: rd_mux = {16'h0000, disp_code[3], disp_code[2], disp_code[1], disp_code[0]};
      `REG_SWITCHES: rd_mux = {20'h0_0000, jmp_s, 2'b00, sw_s};
      default: begin
        rd_mux = '0;
        rd_ok = 1'b0;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  assign jumper_fault = jmp_s[0] ^ jmp_s[1];

  // per loop system: parameters, switch group and frequency selection
  for (genvar s = 0; s < 2; s++) begin : g_sys
    localparam logic [7:0] SYS_ADDR = (s == 0) ? `REG_SYS0 : `REG_SYS1;
    logic [3:0] grp;
    logic [3:0] grp_prev_r;
    logic [31:0] sys_new;
    logic [3:0] sys_nxt;
    logic [3:0] chan_fault;
    assign grp = sw_s[s*4 +: 4];
    assign sys_new = merge({28'h000_0000, sys_r[s]}, wdata_r, wstrb_r);
    always_comb begin
      sys_nxt = sys_new[3:0];
      if (grp[`SW_ACT]) begin
        sys_nxt[`SYS_FRQ_MSB:`SYS_FRQ_LSB] = sys_r[s][`SYS_FRQ_MSB:`SYS_FRQ_LSB];
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sys_r[s] <= `SYS_RST;
        grp_prev_r <= '0;
        sys_realign[s] <= 1'b0;
      end else begin
        grp_prev_r <= grp;
        sys_realign[s] <= grp != grp_prev_r;
        if (wr_fire && awaddr_r == SYS_ADDR) begin
          sys_r[s] <= sys_nxt;
          // an auto-recalibration flag change alone never retunes a loop
          if (sys_nxt[`SYS_EN_BIT] != sys_r[s][`SYS_EN_BIT] ||
              sys_nxt[`SYS_FRQ_MSB:`SYS_FRQ_LSB] != sys_r[s][`SYS_FRQ_MSB:`SYS_FRQ_LSB]) begin
            sys_realign[s] <= 1'b1;
          end
        end
      end
    end
    assign type_fault[s] = grp[`SW_ACT] & (grp[`SW_TYPE] != SUPPORTED_TYPE);
    assign chan_fault = {2'b00, faulty[s*2+1], faulty[s*2]};
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        freq_range[s*2 +: 2] <= 2'b00;
        serial_freq_block[s] <= 1'b0;
        class_degraded[s] <= 1'b0;
      end else begin
        freq_range[s*2 +: 2] <= grp[`SW_ACT] ? {grp[`SW_F1], grp[`SW_F0]} :
                                sys_r[s][`SYS_FRQ_MSB:`SYS_FRQ_LSB];
        serial_freq_block[s] <= grp[`SW_ACT];
        class_degraded[s] <= sys_r[s][`SYS_EN_BIT] & (chan_fault[0] ^ chan_fault[1]);
      end
    end
  end

  // per channel alignment sequencer, error state and indicator
  for (genvar i = 0; i < 4; i++) begin : g_ch
    localparam int S = i / 2;
    loop_pkg::ch_state_t state_r;
    logic pend_r;
    logic dist_r;
    logic ignore_r;
    logic [`MS_W-1:0] ams_r;
    logic [`MS_W-1:0] retry_r;
    logic en;
    logic auto_rc;
    // both channels of a system read the first channel's settings
    assign en = sys_r[S][`SYS_EN_BIT];
    assign auto_rc = sys_r[S][`SYS_AR_BIT];
    always_comb begin
      if (jumper_fault) begin
        disp_code[i] = loop_pkg::ERR_JUMPER;
      end else if (type_fault[S]) begin
        disp_code[i] = loop_pkg::ERR_LOOPTYPE;
      end else begin
        disp_code[i] = err_r[i];
      end
    end
    assign faulty[i] = en & (disp_code[i] != loop_pkg::ERR_NONE);
    always_ff @(posedge aclk) begin
      if (!aresetn || dev_rst) begin
        state_r <= loop_pkg::CH_IDLE;
        pend_r <= 1'b1;
        err_r[i] <= loop_pkg::ERR_NONE;
        chan_aligning[i] <= 1'b0;
        dist_r <= 1'b0;
        ignore_r <= 1'b0;
        ams_r <= '0;
        retry_r <= '0;
      end else begin
        if (!chan_detect[i]) begin
          ignore_r <= 1'b0;
        end
        case (state_r)
          loop_pkg::CH_IDLE: begin
            if (!en) begin
              pend_r <= 1'b0;
              err_r[i] <= loop_pkg::ERR_NONE;
            end else if (pend_r) begin
              state_r <= loop_pkg::CH_ALIGN;
              chan_aligning[i] <= 1'b1;
              pend_r <= 1'b0;
              dist_r <= 1'b0;
              ams_r <= '0;
              retry_r <= '0;
              err_r[i] <= loop_pkg::ERR_NONE;
            end else if (auto_rc && err_r[i] != loop_pkg::ERR_NONE && ms_tick) begin
              // retry period sits well inside the one minute recovery bound
              if (retry_r >= `RETRY_MS - 1'b1) begin
                pend_r <= 1'b1;
                retry_r <= '0;
              end else begin
                retry_r <= retry_r + 1'b1;
              end
            end
          end
          loop_pkg::CH_ALIGN: begin
            if (ms_tick) begin
              ams_r <= ams_r + 1'b1;
            end
            if (ams_r >= `DISTURB_MS) begin
              dist_r <= 1'b1;
            end
            if (!en) begin
              state_r <= loop_pkg::CH_IDLE;
              chan_aligning[i] <= 1'b0;
            end else if (meas_done[i]) begin
              state_r <= loop_pkg::CH_IDLE;
              chan_aligning[i] <= 1'b0;
              ignore_r <= 1'b1;
              if (meas_short[i]) begin
                err_r[i] <= loop_pkg::ERR_SHORT;
              end else if (meas_open[i]) begin
                err_r[i] <= loop_pkg::ERR_OPEN;
              end else if (meas_freq_bad[i]) begin
                err_r[i] <= loop_pkg::ERR_FREQ;
              end else if (dist_r) begin
                err_r[i] <= loop_pkg::ERR_DISTURB;
              end
            end else if (ams_r >= align_max_r) begin
              state_r <= loop_pkg::CH_IDLE;
              chan_aligning[i] <= 1'b0;
              ignore_r <= 1'b1;
              err_r[i] <= loop_pkg::ERR_TIMEOUT;
            end
          end
          default: state_r <= loop_pkg::CH_IDLE;
        endcase
        // last, so a request never loses to a clear
        if (btn_align || sys_realign[S]) begin
          pend_r <= 1'b1;
        end
      end
    end

    blink_coder u_blink (
      .aclk(aclk),
      .aresetn(aresetn),
      .ms_tick(ms_tick),
      .code(disp_code[i]),
      .blink(blink[i])
    );

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        detect_out[i] <= 1'b0;
        channel_indicators[i] <= 1'b0;
      end else begin
        // a vehicle sitting on the loop at the end of alignment stays unseen
        detect_out[i] <= en & ~chan_aligning[i] & ~ignore_r & ~faulty[i] & chan_detect[i];
        if (blank_r) begin
          channel_indicators[i] <= 1'b0;
        end else if (chan_aligning[i]) begin
          channel_indicators[i] <= 1'b1;
        end else if (faulty[i]) begin
          channel_indicators[i] <= blink[i];
        end else begin
          channel_indicators[i] <= detect_out[i];
        end
      end
    end
  end

  // short press toggles blanking of every indicator, the terminal fault output is not blanked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blank_r <= 1'b0;
    end else if (btn_short && blank_to_r != 8'h00) begin
      blank_r <= ~blank_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hb_cnt_r <= '0;
      hb_r <= 1'b0;
    end else if (ms_tick) begin
      if ((chan_aligning != 4'h0 && hb_cnt_r >= `HB_ALIGN_MS - 1'b1) ||
          (chan_aligning == 4'h0 && sync_en_r && hb_cnt_r >= `HB_SYNC_MS - 1'b1) ||
          (chan_aligning == 4'h0 && !sync_en_r && hb_cnt_r >= `HB_NORMAL_MS - 1'b1)) begin
        hb_cnt_r <= '0;
        hb_r <= ~hb_r;
      end else begin
        hb_cnt_r <= hb_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      heartbeat_indicator <= 1'b0;
      rx_indicator <= 1'b0;
      tx_indicator <= 1'b0;
      fault_indicator <= 1'b0;
      fault_output <= 1'b0;
    end else begin
      heartbeat_indicator <= ~blank_r & hb_r;
      rx_indicator <= ~blank_r & rx_busy;
      tx_indicator <= ~blank_r & tx_busy;
      fault_indicator <= ~blank_r & (faulty != 4'h0);
      fault_output <= faulty != 4'h0;
    end
  end
endmodule

// ---- hdl/loop_params.svh ----
// constants for the loop detector front panel and alignment supervisor
// Summary of operation
// - four channel indicators show detection unless an error or alignment overrides.
// - receive and transmit indicators light while the data bus is busy.
// - heartbeat toggles at 1 Hz, or 0.5 Hz with master-slave sync enabled.
// - press under 1 s toggles all indicators; suppressed when blank timeout is zero.
// - press of 1 to 3 s aligns every enabled channel without reset.
// - press over 3 s resets the detector, then aligns all enabled channels.
// - fourth switch of each group activates the group and blocks serial frequency.
// - activated group switches select one of four oscillator frequency ranges.
// - unsupported loop type lights fault and blinks the channel eight times.
// - any change of a group's switches realigns its loop system.
// - no detections while aligning; channel ends alignment undetected.
// - power-on, parameter change, button, external or internal reset start alignment.
// - resets align all enabled channels; parameter writes realign only changed systems.
// - aligning channel indicator steady on, heartbeat flashes near 5 Hz.
// - faulty channel repeats its error blink count every 5 s.
// - any channel error drives collective fault indicator and terminal output.
// - mismatched frequency jumpers flag jumper fault on every channel.
// - alignment lasting beyond about 2 s flags disturbance.
// - alignment over the maximum duration aborts with timeout error.
// - auto recalibration realigns faulty channels cyclically; jumper and type errors stay.
// - one faulty loop leaves the other running; classification degrades.
// - second channel of each system follows the first channel's parameters.
`ifndef LOOP_PARAMS_SVH
`define LOOP_PARAMS_SVH
`define CLK_MHZ 250
`define TICK_US 1000
`define MS_W 16
`define DEBOUNCE_MS 16'h0014
`define SHORT_MAX_MS 16'h03E8
`define RESET_MIN_MS 16'h0BB8
`define DISTURB_MS 16'h07D0
`define BLINK_SLOT_MS 16'h01F4
`define BLINK_ON_MS 16'h00FA
`define BURST_SLOTS 4'hA
`define HB_NORMAL_MS 16'h01F4
`define HB_SYNC_MS 16'h03E8
`define HB_ALIGN_MS 16'h0064
`define RETRY_MS 16'h7530
`define ALIGN_LIMIT_RST 16'h2710
`define REG_CTRL 8'h00
`define REG_ALIGN_MAX 8'h04
`define REG_SYS0 8'h08
`define REG_SYS1 8'h0C
`define REG_STATUS 8'h10
`define REG_ERRORS 8'h14
`define REG_SWITCHES 8'h18
`define CTRL_SYNC_BIT 0
`define CTRL_BLANK_LSB 8
`define CTRL_BLANK_MSB 15
`define SYS_EN_BIT 0
`define SYS_AR_BIT 1
`define SYS_FRQ_LSB 2
`define SYS_FRQ_MSB 3
`define SYS_RST 4'hD
`define BLANK_RST 8'h0A
`define SW_TYPE 0
`define SW_F0 1
`define SW_F1 2
`define SW_ACT 3
`define LOOP_TYPE_OK 1'b1
`define PIN_SYNC_RST 12'h801
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ---- hdl/loop_pkg.sv ----
// types shared by the loop detector supervisor modules
package loop_pkg;
  typedef enum logic [3:0] {
    ERR_NONE = 4'b0000,
    ERR_SHORT = 4'b0001,
    ERR_OPEN = 4'b0010,
    ERR_FREQ = 4'b0011,
    ERR_DISTURB = 4'b0100,
    ERR_JUMPER = 4'b0101,
    ERR_TIMEOUT = 4'b0111,
    ERR_LOOPTYPE = 4'b1000
  } err_code_t;
  typedef enum logic {BTN_IDLE = 1'b0, BTN_HELD = 1'b1} btn_state_t;
  typedef enum logic {CH_IDLE = 1'b0, CH_ALIGN = 1'b1} ch_state_t;
endpackage

// ---- hdl/button_classifier.sv ----
// debounce and hold-time classification of the front multi-function button
`include "loop_params.svh"
module button_classifier (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // millisecond tick and synchronised button level
  input wire logic ms_tick,
  input wire logic pressed,
  // one-cycle press classes
  output logic short_press,
  output logic align_press,
  output logic reset_press
);
  logic stable_r;
  logic [`MS_W-1:0] db_cnt_r;
  logic [`MS_W-1:0] hold_r;
  loop_pkg::btn_state_t state_r;

  // a level must persist for the debounce time before it is believed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stable_r <= 1'b0;
      db_cnt_r <= '0;
    end else if (pressed == stable_r) begin
      db_cnt_r <= '0;
    end else if (ms_tick) begin
      if (db_cnt_r >= `DEBOUNCE_MS) begin
        stable_r <= pressed;
        db_cnt_r <= '0;
      end else begin
        db_cnt_r <= db_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= loop_pkg::BTN_IDLE;
      hold_r <= '0;
      short_press <= 1'b0;
      align_press <= 1'b0;
      reset_press <= 1'b0;
    end else begin
      short_press <= 1'b0;
      align_press <= 1'b0;
      reset_press <= 1'b0;
      case (state_r)
        loop_pkg::BTN_IDLE: begin
          if (stable_r) begin
            state_r <= loop_pkg::BTN_HELD;
            hold_r <= '0;
          end
        end
        loop_pkg::BTN_HELD: begin
          if (ms_tick && hold_r != '1) begin
            hold_r <= hold_r + 1'b1;
          end
          // classed at release, so a long hold never fires the shorter actions
          if (!stable_r) begin
            state_r <= loop_pkg::BTN_IDLE;
            if (hold_r < `SHORT_MAX_MS) begin
              short_press <= 1'b1;
            end else if (hold_r <= `RESET_MIN_MS) begin
              align_press <= 1'b1;
            end else begin
              reset_press <= 1'b1;
            end
          end
        end
        default: state_r <= loop_pkg::BTN_IDLE;
      endcase
    end
  end
endmodule

// ---- hdl/blink_coder.sv ----
// repeating blink burst that shows one channel error code
`include "loop_params.svh"
module blink_coder (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // timing and code
  input wire logic ms_tick,
  input wire loop_pkg::err_code_t code,
  // indicator level
  output logic blink
);
  logic [`MS_W-1:0] sub_r;
  logic [3:0] slot_r;

  // ten half-second slots make the 5 s burst period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sub_r <= '0;
      slot_r <= '0;
    end else if (ms_tick) begin
      if (sub_r == `BLINK_SLOT_MS - 1'b1) begin
        sub_r <= '0;
        slot_r <= (slot_r == `BURST_SLOTS - 1'b1) ? 4'h0 : slot_r + 1'b1;
      end else begin
        sub_r <= sub_r + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink <= 1'b0;
    end else begin
      blink <= (code != loop_pkg::ERR_NONE) && (slot_r < code) && (sub_r < `BLINK_ON_MS);
    end
  end
endmodule

// ---- bench/loop_panel_sva.sv ----
// checker of the loop panel outputs
module loop_panel_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // watched ports
  input wire logic rx_busy,
  input wire logic tx_busy,
  input wire logic rx_indicator,
  input wire logic tx_indicator,
  input wire logic fault_output,
  input wire logic [1:0] freq_jumpers,
  input wire logic [1:0] serial_freq_block,
  input wire logic [7:0] dip_switches,
  input wire logic [3:0] chan_detect,
  input wire logic [3:0] detect_out,
  input wire logic [3:0] chan_aligning,
  input wire logic [3:0] channel_indicators,
  input wire logic [3:0] meas_done,
  input wire logic [3:0] meas_short
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_short0; chan_aligning[0] && meas_done[0] ##0 meas_short[0]; endsequence
  property p_rx; !rx_busy |=> !rx_indicator; endproperty
  a_rx: assert property (p_rx) else $error("rx");
  property p_tx; !tx_busy |=> !tx_indicator; endproperty
  a_tx: assert property (p_tx) else $error("tx");
  property p_al; (chan_aligning & $past(chan_aligning) & detect_out) == 4'h0; endproperty
  a_al: assert property (p_al) else $error("al");
  property p_det; (detect_out & ~$past(chan_detect)) == 4'h0; endproperty
  a_det: assert property (p_det) else $error("det");
  property p_ind; ($past(chan_aligning, 2) & $past(chan_aligning) & ~channel_indicators) == 4'h0; endproperty
  a_ind: assert property (p_ind) else $error("ind");
  property p_jmp; (freq_jumpers[0] != freq_jumpers[1]) [*8] |-> fault_output; endproperty
  a_jmp: assert property (p_jmp) else $error("jmp");
  // synchroniser depth is covered by six stable samples
  property p_act; $stable(dip_switches) [*6] |-> serial_freq_block == {dip_switches[7], dip_switches[3]}; endproperty
  a_act: assert property (p_act) else $error("act");
  property p_flt; s_short0 |-> ##[1:4] fault_output; endproperty
  a_flt: assert property (p_flt) else $error("flt");
endmodule
bind loop_panel loop_panel_sva chk (.*);

// ---- bench/meas_model.sv ----
// measurement side: ends each alignment after a delay
module meas_model (
  // clock
  input wire logic aclk,
  // requests and test controls
  input wire logic [3:0] chan_aligning,
  input wire logic short0,
  input wire logic slow,
  // results
  output logic [3:0] meas_done = 4'h0,
  output logic [3:0] meas_short = 4'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [4] = '{0, 0, 0, 0};
  // slow answers outlast the disturbance limit
  always @(posedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      cnt[i] <= chan_aligning[i] ? cnt[i] + 1 : 0;
      meas_done[i] <= chan_aligning[i] && cnt[i] == (slow ? 5000 : 40);
    end
    meas_short <= {3'h0, short0};
  end
endmodule

// ---- bench/test_loop_panel.sv ----
// self-checking bench of the loop panel supervisor
`include "loop_params.svh"
module test_loop_panel;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 2;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic button_n, ext_reset_n, int_reset, rx_busy, tx_busy, heartbeat_indicator, rx_indicator, tx_indicator;
  logic fault_indicator, fault_output, detector_reset, short0, slow, all_al, rst_seen;
  logic [7:0] awaddr, araddr, dip_switches;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, chan_detect, meas_done, meas_short, meas_open, meas_freq_bad, channel_indicators;
  logic [3:0] chan_aligning, detect_out, freq_range;
  logic [1:0] bresp, rresp, freq_jumpers, serial_freq_block, class_degraded;
  logic [33:0] exp_q [$];
  int bad_count, comparisons, cyc;
  loop_panel #(.MS_TICK_CYCLES(MS)) uut (.*);
  meas_model pm (.aclk, .chan_aligning, .short0, .slow, .meas_done, .meas_short);
  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    all_al <= all_al | (chan_aligning == 4'hf);
    rst_seen <= rst_seen | detector_reset;
    if (rvalid && rready) chk("rd", {rresp, rdata}, exp_q.pop_front());
    if (bvalid && bready) chk("wr", {bresp, 32'h0000_0000}, exp_q.pop_front());
    if (cyc == 60000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // each bus task lets one edge pass so no signal is driven twice in a step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    exp_q.push_back({`RESP_OKAY, 32'h0000_0000});
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `RESP_OKAY);
    exp_q.push_back({r, d});
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic press(input int ms);
    @(negedge aclk);
    {all_al, rst_seen} = 2'h0;
    @(posedge aclk);
    button_n <= 1'h0;
    repeat (ms * MS) @(posedge aclk);
    button_n <= 1'h1;
    repeat (100) @(posedge aclk);
  endtask
  task automatic settle();
    repeat (20) @(posedge aclk);
    while (chan_aligning !== 4'h0) @(posedge aclk);
  endtask
  task automatic hb(input int e);
    int n;
    logic h;
    n = 0;
    @(heartbeat_indicator);
    h = heartbeat_indicator;
    do begin
      @(posedge aclk);
      n++;
    end while (heartbeat_indicator === h);
    chk("heartbeat", 34'(n), 34'(e));
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, int_reset, rx_busy, tx_busy, short0, slow} = '0;
    {all_al, rst_seen, awaddr, araddr, wdata, dip_switches, freq_jumpers, chan_detect} = '0;
    {meas_open, meas_freq_bad} = 8'h00;
    {button_n, ext_reset_n, wstrb} = 6'h3f;
    void'($urandom(32'h6a4f));
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    rd(8'h00, 32'h0000_0a00);
    rd(8'h04, 32'h0000_2710);
    rd(8'h08, 32'h0000_000d);
    rd(8'h1c, 32'h0000_0000, `RESP_SLVERR);
    wr(8'h10, 32'hffff_ffff);
    settle();
    repeat (400) begin
      @(posedge aclk);
      {chan_detect, rx_busy, tx_busy} <= 6'($urandom);
    end
    hb(500 * MS + 1);
    wr(8'h00, 32'h0000_0a01);
    hb(1000 * MS + 1);
    wr(8'h00, 32'h0000_0a00);
    dip_switches <= 8'h0f;
    settle();
    short0 <= 1'h1;
    dip_switches <= 8'h0d;
    settle();
    rd(8'h14, 32'h0000_0001);
    chk("fault", 34'({fault_indicator, fault_output}), 34'h3);
    chk("range", 34'({class_degraded, freq_range}), 34'h1e);
    slow <= 1'h1;
    dip_switches <= 8'h2d;
    settle();
    rd(8'h14, 32'h0000_4401);
    slow <= 1'h0;
    press(1500);
    chk("align", 34'({all_al, rst_seen}), 34'h2);
    rx_busy <= 1'h1;
    press(200);
    chk("blank", 34'(rx_indicator), 34'h0);
    press(200);
    chk("unblank", 34'(rx_indicator), 34'h1);
    short0 <= 1'h0;
    press(3200);
    chk("reset", 34'({all_al, rst_seen}), 34'h3);
    settle();
    freq_jumpers <= 2'h1;
    repeat (50) @(posedge aclk);
    rd(8'h14, 32'h0000_5555);
    chk("fault", 34'(fault_output), 34'h1);
    end_of_test();
  end
endmodule
